// file: src/rwa_pkg.sv
// Purpose: shared types and constants of the remote I/O word allocator
// Assumes: 50 MHz system clock, one scan per power-up
// Notes: register layouts are the packed structs below, lsb last
package rwa_pkg;
    localparam int WORD_W = 8;
    localparam int CNT_W = 5;
    localparam int SW_W = 5;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 32;

    // timing
    localparam int CLK_KHZ = 50000;
    localparam int SCAN_WAIT_MS = 100;
    localparam int SCAN_WAIT_CYC = SCAN_WAIT_MS * CLK_KHZ;
    localparam int SETTLE_CYC = 4;

    // unit number limits
    localparam logic [3:0] MAX_UNIT_LARGE = 4'h7;
    localparam logic [3:0] MAX_UNIT_FIXED = 4'h4;
    localparam logic [3:0] MAX_UNIT_FOREIGN = 4'h3;
    localparam logic [3:0] MAX_UNIT_SMALL = 4'h1;

    // word figures
    localparam logic [WORD_W-1:0] FIXED_BASE = 8'h32;
    localparam logic [WORD_W-1:0] FIXED_STEP = 8'h0a;
    localparam logic [WORD_W-1:0] SWITCH_OFFSET = 8'hc8;
    localparam logic [5:0] NATIVE_SPAN = 6'h0a;
    localparam logic [5:0] FOREIGN_SPAN = 6'h14;
    localparam logic [5:0] RACK_MAX = 6'h1f;
    localparam logic [SW_W-1:0] SW_MAX = 5'h1f;
    localparam logic [CNT_W-1:0] ONE_WORD = 5'h01;
    localparam logic [CNT_W-1:0] TWO_WORDS = 5'h02;

    // register offsets and base word reset value
    localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 3'h1;
    localparam logic [ADDR_W-1:0] REG_BASE = 3'h2;
    localparam logic [ADDR_W-1:0] REG_SEL = 3'h3;
    localparam logic [ADDR_W-1:0] REG_ENTRY = 3'h4;
    localparam logic [ADDR_W-1:0] REG_RESUME = 3'h5;
    localparam logic [ADDR_W-1:0] REG_COUNT = 3'h6;
    localparam logic [WORD_W-1:0] BASE_RESET = 8'h00;

    typedef enum logic [1:0] {VAR_LARGE, VAR_FIXED, VAR_SMALL} rwa_variant_e;
    typedef enum logic [2:0] {
        KIND_NATIVE, KIND_FOREIGN, KIND_EXPAND, KIND_LINK, KIND_OPTICAL
    } rwa_kind_e;

    // one unit answering the power-up scan
    typedef struct packed {
        rwa_kind_e kind;
        logic [2:0] unit;
        logic term;
        logic [CNT_W-1:0] words;
        logic [2:0] special;
        logic [SW_W-1:0] sw;
        logic pts32;
        logic mixed_dir;
    } rwa_desc_s;

    typedef struct packed {
        logic active;
        logic rel;
        rwa_kind_e kind;
        logic [2:0] special;
        logic [CNT_W-1:0] count;
        logic [WORD_W-1:0] first;
    } rwa_entry_s;

    typedef struct packed {
        logic cap;
        logic dir;
        logic noterm;
        logic overlap;
        logic range;
        logic dup;
    } rwa_err_s;

    typedef struct packed {
        rwa_err_s err;
        logic fail;
        logic run;
    } rwa_status_s;
endpackage

// file: src/rwa_sync3.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/10ps
module rwa_sync3 #(
    parameter int W = 1
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } rwa_sync_s;

    rwa_sync_s q, d;

    always_comb begin
        d = q;
        if (ce) begin
            d.s1 = din;
            d.s2 = q.s1;
            d.s3 = q.s2;
            if (q.s2 == q.s3) begin
                d.o = q.s3;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.o;
endmodule // rwa_sync3

// file: src/rwa_table.sv
// Purpose: small unit table, one write port, registered read
// Assumes: single clock
// Notes: a read of the address being written returns the old word
`timescale 1ns/10ps
module rwa_table #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // write port
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // read port
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [W-1:0] rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0] rd;
    } rwa_table_s;

    rwa_table_s q, d;

    always_comb begin
        d = q;
        if (ce) begin
            if (we) begin
                d.mem[waddr] = wdata;
            end
            d.rd = q.mem[raddr];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rd;
endmodule // rwa_table

// file: src/rwa_alloc.sv
// Purpose: power-up bus scan and I/O word allocation of a remote I/O master
// Assumes: scan descriptors come from link logic on clk, chain order
// Notes: variant strap and transmission error pin are synchronised
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
// Contract
// - racks allocate from base word, slaves in unit order, then resume after master
// - optical and link units take words from their switch settings
// - terminator searched at power-up; units acknowledged only once it is found
// - units absent during the power-up scan stay excluded until next power-up
// - unit number limits: 0-7 large, 0-4 fixed-slot, 0-1 small variants
// - duplicate or out-of-range slave unit numbers do not operate
// - rack words follow mounting order regardless of slot
// - fixed-slot native unit n gets ten words from 50+10n
// - expansion rack takes next unit number's range, number then reserved
// - fixed-slot foreign unit n gets twenty words from 50+10n, n 0-3
// - native special units get special bits; foreign racks capped at 20 words
// - non-fixed master: native special units take ordinary words
// - foreign slave clears data on error, no hold, no expansion rack
// - link unit one or two words, switch 0-31, no word shared
// - fixed-slot switch units sit at switch value plus 200
module rwa_alloc
    import rwa_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int SCAN_CYCLES = SCAN_WAIT_CYC
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // straps and pins
    input wire logic [1:0] variant_strap,
    input wire logic xmit_err,
    // scan descriptor stream
    input wire logic desc_valid,
    input wire rwa_desc_s desc,
    output logic desc_ready,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    // status
    output logic run,
    output logic cfg_err,
    output logic foreign_clear,
    output logic hold_out,
    output logic [WORD_W-1:0] resume_word
);
    localparam int IDX_W = $clog2(DEPTH);
    localparam int TW = $clog2(SCAN_CYCLES + 1);
    localparam int EW = $bits(rwa_entry_s);

    typedef enum logic [1:0] {ST_SETTLE, ST_SCAN, ST_RUN, ST_FAIL} rwa_state_e;

    typedef struct packed {
        rwa_state_e st;
        logic [TW-1:0] tmr;
        rwa_variant_e var_sel;
        logic [2:0] last_unit;
        logic last_foreign;
        logic any_foreign;
        logic [7:0] seen;
        logic [31:0] wmap;
        logic [WORD_W-1:0] next;
        logic [IDX_W:0] n_ent;
        rwa_err_s err;
        logic hold_en;
        logic [WORD_W-1:0] base;
        logic [IDX_W-1:0] sel;
        logic [DATA_W-1:0] rdata;
        logic fclr;
        logic hold;
        logic xerr_prev;
    } rwa_main_s;

    rwa_main_s q, d;
    logic [2:0] pins;
    logic xerr;
    logic [EW-1:0] tbl_rd;
    logic [IDX_W-1:0] tbl_raddr;
    rwa_entry_s ent, rd_ent;
    rwa_err_s eset, eclr;
    logic fire, twr, fixed, rack, ok, e_full;
    logic [3:0] unit_eff, max_u;
    logic [5:0] raw, cap;
    logic [SW_W-1:0] sw_n;

    rwa_sync3 #(.W(3)) u_sync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .din({xmit_err, variant_strap}),
        .dout(pins)
    );
    assign xerr = pins[2];

    // sel written this cycle goes straight to the table so reads may follow
    assign tbl_raddr = (wr && addr == REG_SEL) ? wdata[IDX_W-1:0] : q.sel;

    rwa_table #(.W(EW), .DEPTH(DEPTH)) u_table (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .we(twr),
        .waddr(q.n_ent[IDX_W-1:0]),
        .wdata(ent),
        .raddr(tbl_raddr),
        .rdata(tbl_rd)
    );

    assign desc_ready = ce && q.st == ST_SCAN;
    assign fire = desc_valid && desc_ready;
    assign rd_ent = rwa_entry_s'(tbl_rd);

    always_comb begin
        d = q;
        ent = '0;
        eset = '0;
        eclr = '0;
        twr = 1'b0;
        ok = 1'b0;
        e_full = 1'b0;
        fixed = q.var_sel == VAR_FIXED;
        rack = desc.kind inside {KIND_NATIVE, KIND_FOREIGN, KIND_EXPAND};
        sw_n = desc.sw + 5'h01;
        raw = {1'b0, desc.words};
        cap = RACK_MAX;
        case (q.var_sel)
            VAR_LARGE: max_u = MAX_UNIT_LARGE;
            VAR_FIXED: max_u = (desc.kind == KIND_FOREIGN) ? MAX_UNIT_FOREIGN : MAX_UNIT_FIXED;
            default: max_u = MAX_UNIT_SMALL;
        endcase
        // an expansion rack borrows the number after the last slave
        unit_eff = (desc.kind == KIND_EXPAND) ? {1'b0, q.last_unit} + 4'h1 : {1'b0, desc.unit};
        ent.kind = desc.kind;
        if (rack) begin
            eset.range = unit_eff > max_u;
            if (desc.kind == KIND_EXPAND && (!fixed || q.last_foreign || q.seen == '0)) begin
                eset.range = 1'b1;
            end
            eset.dup = !eset.range && q.seen[unit_eff[2:0]];
            // foreign range spans two numbers
            eset.overlap = fixed && desc.kind == KIND_FOREIGN && !eset.range
                && q.seen[unit_eff[2:0] + 3'h1];
            if (desc.kind == KIND_NATIVE && !fixed) begin
                raw = {1'b0, desc.words} + {3'h0, desc.special};
            end else if (desc.kind != KIND_FOREIGN && fixed) begin
                cap = NATIVE_SPAN;
                ent.special = desc.special;
            end
            if (desc.kind == KIND_FOREIGN) begin
                cap = FOREIGN_SPAN;
            end
            eset.cap = raw > cap;
            ent.count = eset.cap ? cap[CNT_W-1:0] : raw[CNT_W-1:0];
            ent.rel = !fixed;
            if (fixed) begin
                ent.first = WORD_W'(FIXED_BASE + FIXED_STEP * unit_eff);
            end else begin
                ent.first = q.next;
            end
        end else begin
            // switch-set units keep out of the mounting-order count
            eset.range = desc.pts32 && desc.sw == SW_MAX;
            eset.overlap = q.wmap[desc.sw] || (desc.pts32 && !eset.range && q.wmap[sw_n]);
            eset.dir = desc.kind == KIND_OPTICAL && desc.mixed_dir && !fixed;
            ent.count = desc.pts32 ? TWO_WORDS : ONE_WORD;
            ent.first = {3'h0, desc.sw} + (fixed ? SWITCH_OFFSET : '0);
        end
        ok = !(eset.range || eset.dup || eset.overlap || eset.dir);
        ent.active = ok;
        if (!fire) begin
            eset = '0;
        end
        if (ce) begin
            d.rdata = '0;
            d.fclr = 1'b0;
            case (q.st)
                ST_SETTLE: begin
                    d.tmr = q.tmr + 1'b1;
                    // one cycle more than the stages, so the strap has left the synchroniser
                    if (q.tmr == TW'(SETTLE_CYC)) begin
                        d.var_sel = rwa_variant_e'(pins[1:0]);
                        d.tmr = '0;
                        d.st = ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    d.tmr = q.tmr + 1'b1;
                    if (fire) begin
                        e_full = q.n_ent == (IDX_W + 1)'(DEPTH);
                        eset.range = eset.range || e_full;
                        twr = !e_full;
                        if (ok && rack) begin
                            d.seen[unit_eff[2:0]] = 1'b1;
                            if (fixed && desc.kind == KIND_FOREIGN) begin
                                d.seen[unit_eff[2:0] + 3'h1] = 1'b1;
                            end
                            d.last_unit = unit_eff[2:0];
                            d.last_foreign = desc.kind == KIND_FOREIGN;
                            d.any_foreign = q.any_foreign || desc.kind == KIND_FOREIGN;
                            d.next = q.next + {3'h0, ent.count};
                        end else if (ok) begin
                            d.wmap[desc.sw] = 1'b1;
                            if (desc.pts32) begin
                                d.wmap[sw_n] = 1'b1;
                            end
                        end
                        if (!e_full) begin
                            d.n_ent = q.n_ent + 1'b1;
                        end
                        if (desc.term) begin
                            d.st = ST_RUN;
                        end
                    end else if (q.tmr == TW'(SCAN_CYCLES - 1)) begin
                        eset.noterm = 1'b1;
                        d.st = ST_FAIL;
                    end
                end
                ST_RUN, ST_FAIL: begin
                    // later arrivals are never enrolled
                    d.tmr = q.tmr;
                end
                default: d.st = ST_FAIL;
            endcase
            // register writes
            if (wr) begin
                case (addr)
                    REG_CTRL: d.hold_en = wdata[0];
                    REG_STATUS: begin
                        eclr = rwa_err_s'(wdata[$bits(rwa_status_s)-1 -: $bits(rwa_err_s)]);
                    end
                    REG_BASE: d.base = wdata[WORD_W-1:0];
                    REG_SEL: d.sel = wdata[IDX_W-1:0];
                    default: d.sel = q.sel;
                endcase
            end
            // a new error in the clearing cycle survives
            d.err = (q.err & ~eclr) | eset;
            if (rd) begin
                case (addr)
                    REG_CTRL: d.rdata = DATA_W'(q.hold_en);
                    REG_STATUS: d.rdata = DATA_W'({q.err, q.st == ST_FAIL, q.st == ST_RUN});
                    REG_BASE: d.rdata = DATA_W'(q.base);
                    REG_SEL: d.rdata = DATA_W'(q.sel);
                    REG_ENTRY: d.rdata = DATA_W'({rd_ent.active && q.st == ST_RUN, rd_ent.rel,
                        rd_ent.kind, rd_ent.special, rd_ent.count,
                        rd_ent.first + (rd_ent.rel ? q.base : '0)});
                    REG_RESUME: d.rdata = DATA_W'(q.base + q.next);
                    REG_COUNT: d.rdata = DATA_W'(q.n_ent);
                    default: d.rdata = '0;
                endcase
            end
            d.xerr_prev = xerr;
            // foreign racks drop data on error and cannot hold outputs
            d.fclr = xerr && !q.xerr_prev && q.any_foreign && q.st == ST_RUN;
            d.hold = q.hold_en && xerr && q.st == ST_RUN;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.base <= BASE_RESET;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign run = q.st == ST_RUN;
    assign cfg_err = |q.err;
    assign foreign_clear = q.fclr;
    assign hold_out = q.hold;
    assign resume_word = q.base + q.next;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_ready_scan_only: assert property (desc_ready |-> q.st == ST_SCAN)
        else $error("descriptor accepted outside scan");
    a_run_needs_term: assert property ($rose(run) |-> $past(fire) && $past(desc.term))
        else $error("run entered without terminator");
    a_timeout_fails: assert property (ce && q.st == ST_SCAN && !fire
        && q.tmr == TW'(SCAN_CYCLES - 1) |=> q.st == ST_FAIL && q.err.noterm)
        else $error("missing terminator not flagged");
    a_fixed_native: assert property (twr && fixed && desc.kind == KIND_NATIVE && ok
        |-> ent.first == WORD_W'(8'h32 + 8'h0a * desc.unit) && ent.count <= 5'h0a)
        else $error("fixed native word range wrong");
    a_foreign_cap: assert property (twr && desc.kind == KIND_FOREIGN |-> ent.count <= 5'h14)
        else $error("foreign rack above twenty words");
    a_switch_offset: assert property (twr && !rack && fixed
        |-> ent.first == {3'h0, desc.sw} + 8'hc8)
        else $error("switch unit offset wrong");
    a_dup_flag: assert property (fire && rack && desc.kind != KIND_EXPAND
        && desc.unit <= 3'h1 && q.seen[desc.unit] |=> q.err.dup)
        else $error("duplicate unit not flagged");
    a_range_off: assert property (twr && rack && unit_eff > 4'h7 |-> !ent.active)
        else $error("out of range unit enrolled");
    a_seq_words: assert property (fire && ok && rack && !fixed
        |=> q.next == $past(q.next) + {3'h0, $past(ent.count)})
        else $error("mounting order words not advanced");
    a_word_share: assert property (fire && !rack && q.wmap[desc.sw] |-> !ent.active)
        else $error("shared switch word enrolled");
    a_hold_run: assert property (hold_out |-> $past(q.st == ST_RUN) && $past(q.hold_en))
        else $error("hold outside run");
endmodule // rwa_alloc

// file: bench/rwa_far_model.sv
// Purpose: far side of the scan stream: slave racks and switch-set units
// Assumes: bench loads the units in chain order before the scan runs
// Notes: idle stream lines toggle so a stale descriptor is never mistaken for a live one
`timescale 1ns/10ps
module rwa_far_model
    import rwa_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // descriptor stream
    input wire logic desc_ready,
    output logic desc_valid,
    output rwa_desc_s desc
);
    rwa_desc_s q[$];

    // bench queues units nearest first, the terminator at the far end
    task automatic push(input rwa_desc_s d);
        q.push_back(d);
    endtask

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            q.delete();
            desc_valid <= 1'b0;
            desc <= '0;
        end else begin
            if (desc_valid && desc_ready) begin
                void'(q.pop_front());
            end
            if (q.size() > 0) begin
                desc_valid <= 1'b1;
                desc <= q[0];
            end else begin
                desc_valid <= 1'b0;
                desc <= ~desc;
            end
        end
    end
endmodule // rwa_far_model

// file: bench/remote_io_word_allocator_tb.sv
// Purpose: self-checking bench of the power-up scan and word allocation
// Assumes: scan wait shortened to 50 cycles, ce held high
// Notes: random word counts from an lfsr with a fixed seed
`timescale 1ns/10ps
module remote_io_word_allocator_tb;
    import rwa_pkg::*;
    logic clk, reset, ce, xmit_err, wr, rd, desc_valid, desc_ready;
    logic run, cfg_err, foreign_clear, hold_out;
    logic [1:0] variant_strap;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, v;
    logic [WORD_W-1:0] resume_word, b;
    logic [4:0] w0, w1;
    logic [1:0] s0, s1;
    rwa_desc_s desc;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    logic [31:0] seed;

    rwa_alloc #(.DEPTH(16), .SCAN_CYCLES(50)) i_dut (
        .clk(clk), .reset(reset), .ce(ce), .variant_strap(variant_strap),
        .xmit_err(xmit_err), .desc_valid(desc_valid), .desc(desc),
        .desc_ready(desc_ready), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .run(run), .cfg_err(cfg_err), .foreign_clear(foreign_clear),
        .hold_out(hold_out), .resume_word(resume_word));

    rwa_far_model i_far (
        .clk(clk), .reset(reset), .desc_ready(desc_ready), .desc_valid(desc_valid),
        .desc(desc));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction

    function automatic logic [7:0] fix_word(input int u);
        return 8'(50 + 10 * u);
    endfunction

    function automatic logic [7:0] sw_word(input int sw, input logic fixed);
        return fixed ? 8'(sw + 200) : 8'(sw);
    endfunction

    function automatic rwa_desc_s mk(input rwa_kind_e k, input int u, input int t,
                                     input int w, input int s, input int sw,
                                     input int p, input int m);
        rwa_desc_s d;
        d.kind = k;
        d.unit = 3'(u);
        d.term = 1'(t);
        d.words = 5'(w);
        d.special = 3'(s);
        d.sw = 5'(sw);
        d.pts32 = 1'(p);
        d.mixed_dir = 1'(m);
        return d;
    endfunction

    task automatic close_out();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] r);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        r = rdata;
    endtask

    task automatic ent(input int i, output logic [DATA_W-1:0] r);
        wr_reg(REG_SEL, DATA_W'(i));
        rd_reg(REG_ENTRY, r);
    endtask

    task automatic ent_chk(input int i, input logic [7:0] f, input logic [4:0] c,
                           input logic a);
        logic [DATA_W-1:0] r;
        ent(i, r);
        chk({r[20], r[12:8], r[7:0]}, {a, c, f});
    endtask

    task automatic start(input logic [1:0] s);
        reset <= 1'b1;
        variant_strap <= s;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
    endtask

    task automatic wait_run();
        for (int k = 0; k < 60 && run !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        ce = 1'b1;
        reset = 1'b1;
        xmit_err = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        variant_strap = 2'h0;
        seed = 32'h345ada63;
        // fixed-slot rack with expansion, foreign rack and a unit number it already covers
        start(2'h1);
        seed = nxt(seed);
        w0 = {2'b00, seed[2:0]} + 5'h01;
        i_far.push(mk(KIND_NATIVE, 0, 0, w0, seed[4:3], 0, 0, 0));
        i_far.push(mk(KIND_EXPAND, 0, 0, 2, 0, 0, 0, 0));
        i_far.push(mk(KIND_FOREIGN, 3, 0, 12, 0, 0, 0, 0));
        // foreign unit 3 already holds the words of unit 4
        i_far.push(mk(KIND_NATIVE, 4, 0, 1, 0, 0, 0, 0));
        i_far.push(mk(KIND_LINK, 0, 1, 0, 0, 5, 1, 0));
        wait_run();
        chk(run, 1);
        ent_chk(0, fix_word(0), w0, 1'b1);
        ent_chk(1, fix_word(1), 5'h02, 1'b1);
        ent_chk(2, fix_word(3), 5'h0c, 1'b1);
        ent(3, v);
        chk(v[20], 0);
        ent_chk(4, sw_word(5, 1'b1), 5'h02, 1'b1);
        rd_reg(REG_STATUS, v);
        chk(v, 32'h05);
        // a unit turning up after the scan is never taken
        i_far.push(mk(KIND_NATIVE, 2, 0, 1, 0, 0, 0, 0));
        repeat (5) @(posedge clk);
        #1;
        chk(desc_ready, 0);
        rd_reg(REG_COUNT, v);
        chk(v, 5);
        wr_reg(REG_CTRL, 32'h1);
        rd_reg(REG_CTRL, v);
        chk(v, 32'h1);
        @(posedge clk);
        xmit_err <= 1'b1;
        n = 0;
        repeat (12) begin
            @(posedge clk);
            #1;
            if (foreign_clear === 1'b1) n++;
        end
        chk(n, 1);
        chk(hold_out, 1);
        @(posedge clk);
        xmit_err <= 1'b0;
        wr_reg(REG_STATUS, 32'hfc);
        #1;
        chk(cfg_err, 0);
        // large variant, mounting order from a random base
        for (int k = 0; k < 3; k++) begin
            start(2'h0);
            seed = nxt(seed);
            b = {1'b0, seed[6:0]};
            w0 = {2'b00, seed[9:7]} + 5'h01;
            s0 = seed[11:10];
            w1 = {2'b00, seed[14:12]} + 5'h01;
            s1 = seed[16:15];
            wr_reg(REG_BASE, DATA_W'(b));
            i_far.push(mk(KIND_NATIVE, 0, 0, w0, s0, 0, 0, 0));
            i_far.push(mk(KIND_NATIVE, 1, 0, w1, s1, 0, 0, 0));
            i_far.push(mk(KIND_LINK, 0, 1, 0, 0, 9, 0, 0));
            wait_run();
            chk(run, 1);
            ent_chk(0, b, w0 + s0, 1'b1);
            ent_chk(1, b + w0 + s0, w1 + s1, 1'b1);
            ent_chk(2, sw_word(9, 1'b0), 5'h01, 1'b1);
            chk(resume_word, b + w0 + s0 + w1 + s1);
            rd_reg(REG_RESUME, v);
            chk(v, b + w0 + s0 + w1 + s1);
            rd_reg(REG_STATUS, v);
            chk(v, 32'h1);
        end
        // small variant: duplicate, out of range, mixed optical word
        start(2'h2);
        i_far.push(mk(KIND_NATIVE, 0, 0, 1, 0, 0, 0, 0));
        i_far.push(mk(KIND_NATIVE, 0, 0, 1, 0, 0, 0, 0));
        i_far.push(mk(KIND_NATIVE, 2, 0, 1, 0, 0, 0, 0));
        i_far.push(mk(KIND_OPTICAL, 0, 1, 0, 0, 7, 0, 1));
        wait_run();
        rd_reg(REG_STATUS, v);
        chk(v, 32'h4d);
        ent(1, v);
        chk(v[20], 0);
        ent(2, v);
        chk(v[20], 0);
        // no terminator: scan gives up, nothing acknowledged
        start(2'h0);
        i_far.push(mk(KIND_NATIVE, 0, 0, 2, 0, 0, 0, 0));
        repeat (70) @(posedge clk);
        #1;
        rd_reg(REG_STATUS, v);
        chk(v, 32'h22);
        chk(run, 0);
        ent(0, v);
        chk(v[20], 0);
        chk(desc_ready, 0);
        close_out();
    end
endmodule // remote_io_word_allocator_tb
